// *** design/master_clock_source_control.sv ***
// master clock source control: enables, ready flags, divider, trim, emc guard
// Functional notes
// - critical registers kept complementary; mismatch raises the disturbance reset
// - master selectable from crystal, user clock, fast RC, slow RC
// - crystal, fast RC and slow RC each have their own on/off control; the user clock uses the crystal enable
// - crystal held 2048 cycles by default; option may shorten count
// - crystal ready flag set when stable; clock released only then
// - crystal starts or stops with its enable bit
// - user clock option takes input pin clock, frees output pin as I/O
// - above 16 MHz memory accesses use one wait state from option
// - fast RC passes a divider of factor 1 to 8
// - startup master is fast RC divided by 8
// - fast RC ready flag set when stable; output withheld until then
// - fast RC starts or stops with its enable bit
// - fast RC at its current divider serves as backup clock when the crystal fails
// - fast wakeup bit selects fast RC on leaving halt
// - factory calibration loaded into internal register after reset
// - signed 3 or 4 bit trim is added to calibration
// - four-bit trim steps are half the three-bit step width
// - slow RC starts or stops with its enable bit
// - slow RC ready flag set when stable; clock withheld until then
// - slow RC has no software trim
// - slow RC refused as master while permit option cleared
// - slow RC may keep running in halt when the watchdog needs it
`timescale 1ns/1ps
module master_clock_source_control #(
  parameter int TRIM_BITS = 4,
  parameter int EXT_STAB = clk_src_pkg::EXT_STAB_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic extOscTick,
  input wire logic fastRcTick,
  input wire logic slowRcTick,
  input wire logic [11:0] ext_osc_stabilize_count_option,
  input wire logic user_clock_mode_option,
  input wire logic slow_rc_master_permit_option,
  input wire logic waitStateOption,
  input wire logic [7:0] factoryCal,
  input wire logic [1:0] requestSrc,
  input wire logic haltMode,
  input wire logic wakeupEvent,
  input wire logic watchdogNeedsSlow,
  input wire logic extOscFail,
  input wire logic [7:0] disturbFault,
  output logic ext_osc_enable,
  output logic int_fast_rc_enable,
  output logic int_slow_rc_enable,
  output logic extReleased,
  output logic fastRcReleased,
  output logic slowRcReleased,
  output logic [1:0] masterSrc,
  output logic [2:0] fastRcDivLog2,
  output logic [7:0] fastRcTrimCode,
  output logic flashWaitState,
  output logic oscOutPinFree,
  output logic backupClkAvail,
  output logic disturbReset
);
  import clk_src_pkg::*;

  logic [7:0] extReg;
  logic [7:0] intReg;
  logic [7:0] divReg;
  logic [3:0] trimReg;
  logic [7:0] calReg;
  logic extMis;
  logic intMis;
  logic ext_osc_ready_flag;
  logic int_fast_rc_ready_flag;
  logic int_slow_rc_ready_flag;
  logic [11:0] extStabSel;
  logic wrExt;
  logic wrInt;
  logic [7:0] next_regRdata;
  logic [7:0] next_trim;
  logic [1:0] next_masterSrc;
  logic fast_wakeup_select;
  logic [1:0] divField;

  assign wrExt = regWrite && regAddr == EXT_REG_OFS;
  assign wrInt = regWrite && regAddr == INT_REG_OFS;
  assign fast_wakeup_select = intReg[INT_WAKE_BIT];
  assign divField = divReg[DIV_LSB +: 2];

  emc_guard_reg #(.W(8), .RST(EXT_REG_RST)) u_extGuard (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .load(wrExt),
    .wdata({7'h00, regWdata[EXT_EN_BIT]}),
    .corrupt(disturbFault),
    .value(extReg),
    .mismatch(extMis)
  );

  emc_guard_reg #(.W(8), .RST(INT_REG_RST)) u_intGuard (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .load(wrInt),
    .wdata(regWdata & 8'h0d),
    .corrupt(8'h00),
    .value(intReg),
    .mismatch(intMis)
  );

  // option may shorten the count; zero keeps the default
  assign extStabSel = (ext_osc_stabilize_count_option != 12'h000 &&
                       ext_osc_stabilize_count_option < 12'(EXT_STAB)) ?
                      ext_osc_stabilize_count_option : 12'(EXT_STAB);

  osc_ready_timer #(.CW(12)) u_extTimer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .oscEnable(ext_osc_enable),
    .oscTick(extOscTick),
    .stabCount(extStabSel),
    .ready(ext_osc_ready_flag)
  );

  osc_ready_timer #(.CW(12)) u_fastTimer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .oscEnable(int_fast_rc_enable),
    .oscTick(fastRcTick),
    .stabCount(12'(FAST_RC_STAB_CYCLES)),
    .ready(int_fast_rc_ready_flag)
  );

  osc_ready_timer #(.CW(12)) u_slowTimer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .oscEnable(int_slow_rc_enable),
    .oscTick(slowRcTick),
    .stabCount(12'(SLOW_RC_STAB_CYCLES)),
    .ready(int_slow_rc_ready_flag)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ext_osc_enable <= 1'b0;
      int_fast_rc_enable <= 1'b1;
      int_slow_rc_enable <= 1'b0;
    end else if (clkEn) begin
      ext_osc_enable <= extReg[EXT_EN_BIT];
      int_fast_rc_enable <= intReg[INT_FAST_EN_BIT];
      // slow RC enable bit; kept on in halt for watchdog
      int_slow_rc_enable <= intReg[INT_SLOW_EN_BIT] || (haltMode && watchdogNeedsSlow);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      extReleased <= 1'b0;
      fastRcReleased <= 1'b0;
      slowRcReleased <= 1'b0;
    end else if (clkEn) begin
      extReleased <= ext_osc_ready_flag;
      fastRcReleased <= int_fast_rc_ready_flag;
      slowRcReleased <= int_slow_rc_ready_flag;
    end
  end

  // divider register, factor 1 to 8
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      divReg <= {3'h0, DIV_RST, 3'h0};
    end else if (clkEn) begin
      if (regWrite && regAddr == DIV_REG_OFS) begin
        divReg <= {3'h0, regWdata[DIV_LSB +: 2], 3'h0};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      calReg <= CAL_DEFAULT;
      trimReg <= TRIM_RST;
    end else if (clkEn) begin
      calReg <= factoryCal;
      if (regWrite && regAddr == TRIM_REG_OFS) begin
        trimReg <= regWdata[3:0];
      end
    end
  end

  // sign-extended trim added; 3-bit steps doubled in weight
  // no slow RC trim path exists
  always_comb begin
    if (TRIM_BITS == 4) begin
      next_trim = calReg + {{4{trimReg[3]}}, trimReg};
    end else begin
      next_trim = calReg + {{4{trimReg[2]}}, trimReg[2:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fastRcTrimCode <= CAL_DEFAULT;
      fastRcDivLog2 <= {1'b0, DIV_RST};
    end else if (clkEn) begin
      fastRcTrimCode <= next_trim;
      fastRcDivLog2 <= {1'b0, divField};
    end
  end

  always_comb begin
    next_masterSrc = masterSrc;
    if (wakeupEvent && fast_wakeup_select) begin
      next_masterSrc = SRC_FAST_RC;
    end else if (requestSrc == SRC_SLOW_RC) begin
      if (slow_rc_master_permit_option && int_slow_rc_ready_flag) begin
        next_masterSrc = SRC_SLOW_RC;
      end
    end else if (requestSrc == SRC_EXT_XTAL || requestSrc == SRC_EXT_USER) begin
      // failed crystal is not taken back, or master would flip every cycle
      if (ext_osc_ready_flag && !extOscFail) begin
        // user option picks the pin clock
        next_masterSrc = user_clock_mode_option ? SRC_EXT_USER : SRC_EXT_XTAL;
      end
    end else if (int_fast_rc_ready_flag) begin
      next_masterSrc = SRC_FAST_RC;
    end
    if (extOscFail && masterSrc == SRC_EXT_XTAL) begin
      next_masterSrc = SRC_FAST_RC;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      masterSrc <= SRC_FAST_RC;
    end else if (clkEn) begin
      masterSrc <= next_masterSrc;
    end
  end

  // output pin freed; wait state from option; backup
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      oscOutPinFree <= 1'b0;
      flashWaitState <= 1'b0;
      backupClkAvail <= 1'b0;
    end else if (clkEn) begin
      oscOutPinFree <= user_clock_mode_option;
      flashWaitState <= waitStateOption;
      backupClkAvail <= int_fast_rc_ready_flag;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      disturbReset <= 1'b0;
    end else if (clkEn) begin
      disturbReset <= disturbReset || extMis || intMis;
    end
  end

  // read mux, unmapped reads give zero
  always_comb begin
    unique case (regAddr)
      EXT_REG_OFS: next_regRdata = {6'h00, ext_osc_ready_flag, extReg[EXT_EN_BIT]};
      INT_REG_OFS: next_regRdata = {3'h0, int_slow_rc_ready_flag, intReg[3:2],
                                    int_fast_rc_ready_flag, intReg[0]};
      DIV_REG_OFS: next_regRdata = divReg;
      TRIM_REG_OFS: next_regRdata = {4'h0, trimReg};
      STAT_REG_OFS: next_regRdata = {4'h0, oscOutPinFree, 1'b0, masterSrc};
      default: next_regRdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (clkEn) begin
      regRdata <= regRead ? next_regRdata : 8'h00;
    end
  end

  property p_slowPermit;
    @(posedge sys_clk) disable iff (!nrst)
      !slow_rc_master_permit_option |-> ##1 !(masterSrc == SRC_SLOW_RC && $changed(masterSrc));
  endproperty
  a_slowPermit: assert property (p_slowPermit) else $error("slow rc taken without permit");

  property p_extRelease;
    @(posedge sys_clk) disable iff (!nrst)
      extReleased |-> $past(ext_osc_ready_flag);
  endproperty
  a_extRelease: assert property (p_extRelease) else $error("crystal released early");

  property p_disturb;
    @(posedge sys_clk) disable iff (!nrst)
      (clkEn && (extMis || intMis)) |=> disturbReset;
  endproperty
  a_disturb: assert property (p_disturb) else $error("mismatch without reset");

  property p_readyClear;
    @(posedge sys_clk) disable iff (!nrst)
      (clkEn && !ext_osc_enable) |=> !ext_osc_ready_flag;
  endproperty
  a_readyClear: assert property (p_readyClear) else $error("ready kept while off");

  property p_wake;
    @(posedge sys_clk) disable iff (!nrst)
      (clkEn && wakeupEvent && fast_wakeup_select) |=> masterSrc == SRC_FAST_RC;
  endproperty
  a_wake: assert property (p_wake) else $error("fast wakeup ignored");

  property p_fastRelease;
    @(posedge sys_clk) disable iff (!nrst)
      fastRcReleased |-> $past(int_fast_rc_ready_flag);
  endproperty
  a_fastRelease: assert property (p_fastRelease) else $error("fast rc released early");

  property p_slowRelease;
    @(posedge sys_clk) disable iff (!nrst)
      slowRcReleased |-> $past(int_slow_rc_ready_flag);
  endproperty
  a_slowRelease: assert property (p_slowRelease) else $error("slow rc released early");

  property p_crystalEn;
    @(posedge sys_clk) disable iff (!nrst)
      (clkEn && wrExt) ##1 clkEn |=> ext_osc_enable == $past(extReg[EXT_EN_BIT]);
  endproperty
  a_crystalEn: assert property (p_crystalEn) else $error("crystal enable not followed");
endmodule : master_clock_source_control

// *** design/clk_src_pkg.sv ***
// package of constants for the master clock source controller
package clk_src_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] EXT_REG_OFS = 4'h0;
  localparam logic [3:0] INT_REG_OFS = 4'h1;
  localparam logic [3:0] DIV_REG_OFS = 4'h2;
  localparam logic [3:0] TRIM_REG_OFS = 4'h3;
  localparam logic [3:0] STAT_REG_OFS = 4'h4;
  // field positions
  localparam int EXT_EN_BIT = 0;
  localparam int EXT_RDY_BIT = 1;
  localparam int INT_FAST_EN_BIT = 0;
  localparam int INT_FAST_RDY_BIT = 1;
  localparam int INT_SLOW_EN_BIT = 3;
  localparam int INT_SLOW_RDY_BIT = 4;
  localparam int INT_WAKE_BIT = 2;
  localparam int DIV_LSB = 3;
  // reset values
  localparam logic [7:0] EXT_REG_RST = 8'h00;
  localparam logic [7:0] INT_REG_RST = 8'h01;
  localparam logic [1:0] DIV_RST = 2'h3;
  localparam logic [3:0] TRIM_RST = 4'h0;
  localparam logic [7:0] CAL_DEFAULT = 8'h80;
  // timing counts in oscillator cycles, clock rates in Hz
  localparam int EXT_STAB_CYCLES = 2048;
  localparam int FAST_RC_STAB_CYCLES = 16;
  localparam int SLOW_RC_STAB_CYCLES = 16;
  localparam int SYS_CLK_HZ = 20000000;
  localparam int FAST_RC_HZ = 16000000;
  localparam int SLOW_RC_HZ = 128000;
  localparam int USER_CLK_MAX_HZ = 24000000;
  // master source codes
  typedef enum logic [1:0] {
    SRC_FAST_RC = 2'b00,
    SRC_EXT_XTAL = 2'b01,
    SRC_EXT_USER = 2'b10,
    SRC_SLOW_RC = 2'b11
  } src_e;
endpackage : clk_src_pkg

// *** design/osc_ready_timer.sv ***
// stabilization timer producing one oscillator ready flag
`timescale 1ns/1ps
module osc_ready_timer #(
  parameter int CW = 12
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic oscEnable,
  input wire logic oscTick,
  input wire logic [CW-1:0] stabCount,
  output logic ready
);
  import clk_src_pkg::*;
  logic [CW-1:0] count;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      ready <= 1'b0;
    end else if (clkEn) begin
      if (!oscEnable) begin
        count <= '0;
        ready <= 1'b0;
      end else if (!ready && oscTick) begin
        if (count == stabCount - CW'(1)) begin
          ready <= 1'b1;
        end else begin
          count <= count + CW'(1);
        end
      end
    end
  end
endmodule : osc_ready_timer

// *** design/emc_guard_reg.sv ***
// register held as a true and a complemented copy
`timescale 1ns/1ps
module emc_guard_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic load,
  input wire logic [W-1:0] wdata,
  input wire logic [W-1:0] corrupt,
  output logic [W-1:0] value,
  output logic mismatch
);
  logic [W-1:0] truePart;
  logic [W-1:0] invPart;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      truePart <= RST;
      invPart <= ~RST;
    end else if (clkEn) begin
      if (load) begin
        truePart <= wdata;
        invPart <= ~wdata;
      end else begin
        truePart <= truePart ^ corrupt;
      end
    end
  end

  assign value = truePart;
  assign mismatch = (truePart != ~invPart);
endmodule : emc_guard_reg

// *** test/osc_model.sv ***
// oscillator side model for the clock source block
`timescale 1ns/1ps
module osc_model #(
  parameter int EXT_PER = 3
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic extEn,
  input wire logic fastEn,
  input wire logic slowEn,
  output logic extTick,
  output logic fastTick,
  output logic slowTick
);
  logic [3:0] phase;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= 4'h0;
    end else begin
      phase <= (phase == 4'(EXT_PER - 1)) ? 4'h0 : phase + 4'h1;
    end
  end
  // one tick every EXT_PER cycles
  // slow crystal, so stabilization takes visible time
  assign extTick = extEn && phase == 4'h0;
  // stopped oscillators give no ticks at all
  assign fastTick = fastEn;
  assign slowTick = slowEn && phase == 4'h1;
endmodule : osc_model

// *** test/master_clock_source_control_bench.sv ***
// self-checking bench for the master clock source control block
`timescale 1ns/1ps
module master_clock_source_control_bench;
  import clk_src_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic extTick, fastTick, slowTick;
  logic userOpt = 1'b0;
  logic clkEn = 1'b1;
  logic waitOpt = 1'b0;
  logic waitSt;
  logic [11:0] stabOpt = 12'h000;
  logic permitOpt = 1'b0;
  logic [1:0] reqSrc = 2'h0;
  logic halt = 1'b0;
  logic wake = 1'b0;
  logic wdSlow = 1'b0;
  logic extFail = 1'b0;
  logic [7:0] fault = 8'h00;
  logic extEn, fastEn, slowEn, extRel, fastRel, slowRel;
  logic [1:0] mSrc;
  logic [2:0] divLog;
  logic [7:0] trimCode;
  logic pinFree, backup, distRst;
  int num_errors = 0;
  int checks_done = 0;

  always #25 sys_clk = ~sys_clk;

  master_clock_source_control #(.TRIM_BITS(4), .EXT_STAB(8)) DUT (
    .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata),
    .extOscTick(extTick), .fastRcTick(fastTick), .slowRcTick(slowTick),
    .ext_osc_stabilize_count_option(stabOpt),
    .user_clock_mode_option(userOpt),
    .slow_rc_master_permit_option(permitOpt),
    .waitStateOption(waitOpt), .factoryCal(8'h5a), .requestSrc(reqSrc),
    .haltMode(halt), .wakeupEvent(wake), .watchdogNeedsSlow(wdSlow),
    .extOscFail(extFail), .disturbFault(fault),
    .ext_osc_enable(extEn), .int_fast_rc_enable(fastEn),
    .int_slow_rc_enable(slowEn), .extReleased(extRel),
    .fastRcReleased(fastRel), .slowRcReleased(slowRel),
    .masterSrc(mSrc), .fastRcDivLog2(divLog), .fastRcTrimCode(trimCode),
    .flashWaitState(waitSt), .oscOutPinFree(pinFree),
    .backupClkAvail(backup), .disturbReset(distRst)
  );

  osc_model #(.EXT_PER(3)) osc (
    .sys_clk(sys_clk), .nrst(nrst), .extEn(extEn), .fastEn(fastEn),
    .slowEn(slowEn), .extTick(extTick), .fastTick(fastTick),
    .slowTick(slowTick)
  );

  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 chk(n, {4'h0, e}, {4'h0, regRdata});
  endtask : rd

  task automatic t_reset();
    #1 chk("masterSrc", 12'h0, {10'h0, mSrc});
    chk("divLog", 12'h3, {9'h0, divLog});
    chk("fastEn", 12'h1, {11'h0, fastEn});
    chk("extEn", 12'h0, {11'h0, extEn});
    chk("waitSt", 12'h0, {11'h0, waitSt});
    rd(INT_REG_OFS, INT_REG_RST, "intReg");
    rd(EXT_REG_OFS, EXT_REG_RST, "extReg");
    rd(DIV_REG_OFS, {3'h0, DIV_RST, 3'h0}, "divReg");
    rd(4'hf, 8'h00, "unmapped");
    chk("trimCode", 12'h05a, {4'h0, trimCode});
    $display("reset test done");
  endtask : t_reset

  task automatic t_fast();
    for (int i = 0; i < 40 && fastRel !== 1'b1; i++) @(negedge sys_clk);
    chk("fastRel", 12'h1, {11'h0, fastRel});
    rd(INT_REG_OFS, 8'h03, "intRdy");
    $display("fast rc test done");
  endtask : t_fast

  task automatic t_xtal();
    wr(EXT_REG_OFS, 8'h01);
    @(posedge sys_clk);
    #1 chk("extEn", 12'h1, {11'h0, extEn});
    repeat (10) @(posedge sys_clk);
    #1 chk("extEarly", 12'h0, {11'h0, extRel});
    for (int i = 0; i < 60 && extRel !== 1'b1; i++) @(negedge sys_clk);
    chk("extRel", 12'h1, {11'h0, extRel});
    rd(EXT_REG_OFS, 8'h03, "extRdy");
    @(posedge sys_clk);
    reqSrc <= 2'h1;
    repeat (4) @(posedge sys_clk);
    #1 chk("xtalMaster", 12'h1, {10'h0, mSrc});
    @(posedge sys_clk);
    extFail <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk("backupSrc", 12'h0, {10'h0, mSrc});
    chk("backup", 12'h1, {11'h0, backup});
    @(posedge sys_clk);
    extFail <= 1'b0;
    reqSrc <= 2'h0;
    wr(EXT_REG_OFS, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1 chk("extOff", 12'h0, {10'h0, extEn, extRel});
    rd(EXT_REG_OFS, 8'h00, "extClr");
    // shortened count: two ticks release well before the default eight
    @(posedge sys_clk);
    stabOpt <= 12'h002;
    wr(EXT_REG_OFS, 8'h01);
    repeat (12) @(posedge sys_clk);
    #1 chk("extShort", 12'h1, {11'h0, extRel});
    wr(EXT_REG_OFS, 8'h00);
    stabOpt <= 12'h000;
    $display("crystal test done");
  endtask : t_xtal

  task automatic t_div();
    for (int n = 0; n < 4; n++) begin
      wr(DIV_REG_OFS, 8'(n << DIV_LSB));
      @(posedge sys_clk);
      #1 chk("divLog", 12'(n), {9'h0, divLog});
    end
    $display("divider test done");
  endtask : t_div

  task automatic t_freeze();
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(DIV_REG_OFS, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk("frozenDiv", 12'h3, {9'h0, divLog});
    @(posedge sys_clk);
    clkEn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk("divKept", 12'h3, {9'h0, divLog});
    $display("clock enable test done");
  endtask : t_freeze

  task automatic t_trim();
    logic [3:0] tv [3] = '{4'h7, 4'h8, 4'hf};
    foreach (tv[i]) begin
      wr(TRIM_REG_OFS, {4'h0, tv[i]});
      repeat (3) @(posedge sys_clk);
      #1 chk("trim", {4'h0, 8'h5a + {{4{tv[i][3]}}, tv[i]}}, {4'h0, trimCode});
    end
    $display("trim test done");
  endtask : t_trim

  task automatic t_slow();
    wr(INT_REG_OFS, 8'h09);
    @(posedge sys_clk);
    #1 chk("slowEn", 12'h1, {11'h0, slowEn});
    for (int i = 0; i < 80 && slowRel !== 1'b1; i++) @(negedge sys_clk);
    chk("slowRel", 12'h1, {11'h0, slowRel});
    rd(INT_REG_OFS, 8'h1b, "intSlow");
    @(posedge sys_clk);
    reqSrc <= 2'h3;
    repeat (5) @(posedge sys_clk);
    #1 chk("noPermit", 12'h0, {10'h0, mSrc});
    @(posedge sys_clk);
    permitOpt <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 chk("slowMaster", 12'h3, {10'h0, mSrc});
    $display("slow rc test done");
  endtask : t_slow

  task automatic t_wake();
    // slow enable bit off, so only the halt path keeps it running
    wr(INT_REG_OFS, 8'h05);
    halt <= 1'b1;
    wdSlow <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk("haltSlow", 12'h1, {11'h0, slowEn});
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    halt <= 1'b0;
    for (int i = 0; i < 4 && mSrc !== 2'h0; i++) @(negedge sys_clk);
    chk("wakeSrc", 12'h0, {10'h0, mSrc});
    @(posedge sys_clk);
    reqSrc <= 2'h0;
    wdSlow <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk("slowOff", 12'h0, {11'h0, slowEn});
    $display("wakeup test done");
  endtask : t_wake

  task automatic t_user();
    @(posedge sys_clk);
    userOpt <= 1'b1;
    waitOpt <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk("pinFree", 12'h1, {11'h0, pinFree});
    chk("waitSt", 12'h1, {11'h0, waitSt});
    rd(STAT_REG_OFS, 8'h08, "status");
    $display("user clock test done");
  endtask : t_user

  task automatic t_emc();
    chk("noDist", 12'h0, {11'h0, distRst});
    @(posedge sys_clk);
    fault <= 8'h01;
    @(posedge sys_clk);
    fault <= 8'h00;
    repeat (3) @(posedge sys_clk);
    #1 chk("distRst", 12'h1, {11'h0, distRst});
    $display("emc test done");
  endtask : t_emc

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // generous span: all tests need well under 2000 cycles
  initial begin
    #(50 * 20000);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_fast();
    t_xtal();
    t_div();
    t_freeze();
    t_trim();
    t_slow();
    t_wake();
    t_user();
    t_emc();
    print_verdict();
  end
endmodule : master_clock_source_control_bench
